// >>> design/hwmri_consts.vh
// How it works
// R1 - Seven-bit pointer in index port bits
// R2 - Busy bit set by index write/serial
// R3 - Host avoids parallel access during serial
// R4 - Data port reads/writes selected location
// R5 - Upper value range auto-increments pointer
// R6 - Status one access advances to two
// R7 - Mask first access advances to second
// R8 - Start bit runs loop; standby keeps irqs
// R9 - Enable bits gate each interrupt output
// R10 - Hold bit forces irqs off, halts loop
// R11 - Reset bit pulses reset 20 ms
// R12 - Select bit picks nmi or irq
// R13 - Power hold bit pulls output low
// R14 - Soft init restores defaults except address
// R15 - Configuration resets to 0000_1000
// R16 - Status one bit layout
// R17 - Status two bit layout, bit7 zero
// R18 - Buffer overflow sets status two bit5
// R19 - Management masks block matching status bits
// R20 - Status read returns then clears
// R21 - Host line has own masks
// R22 - Output low when unmasked, enabled, unheld
`ifndef HWMRI_CONSTS_VH
`define HWMRI_CONSTS_VH
`define HWMRI_A_CFG 7'h40
`define HWMRI_A_ST1 7'h41
`define HWMRI_A_ST2 7'h42
`define HWMRI_A_MM1 7'h43
`define HWMRI_A_MM2 7'h44
`define HWMRI_A_HM1 7'h45
`define HWMRI_A_HM2 7'h46
`define HWMRI_A_VFD 7'h47
`define HWMRI_A_SBA 7'h48
`define HWMRI_A_CRI 7'h49
`define HWMRI_PORT_IDX 3'h5
`define HWMRI_PORT_DAT 3'h6
`define HWMRI_PORT_PC0 3'h0
`define HWMRI_PORT_PC4 3'h4
`define HWMRI_BUF_LAST 7'h1f
`define HWMRI_VAL_LO 7'h20
`define HWMRI_VAL_HI 7'h3f
`define HWMRI_VALI_LO 7'h60
`define HWMRI_RST_CFG 8'h08
`define HWMRI_RST_HM2 8'h40
`define HWMRI_RST_VFD 4'h5
`define HWMRI_RST_SBA 7'h2d
`define HWMRI_CFG_START 0
`define HWMRI_CFG_MEN 1
`define HWMRI_CFG_HEN 2
`define HWMRI_CFG_HOLD 3
`define HWMRI_CFG_RST 4
`define HWMRI_CFG_SEL 5
`define HWMRI_CFG_PWR 6
`define HWMRI_CFG_INIT 7
`define HWMRI_MM2_RSTEN 7
`define HWMRI_PULSE_NS 20000000
`define HWMRI_CLK_NS 10
`define HWMRI_PULSE_CYC ((`HWMRI_PULSE_NS + `HWMRI_CLK_NS - 1) / `HWMRI_CLK_NS)
`endif

// >>> design/hwmri_top.v
`timescale 1ns/10ps
`include "hwmri_consts.vh"
module hwmri_top #(
  parameter PULSE_CYC = `HWMRI_PULSE_CYC,
  // Identity bit, value is arbitrary
  parameter DEV_ID = 1'b1
) (
  input wire clk,
  input wire rst,
  input wire io_rd_n,
  input wire io_wr_n,
  input wire [2:0] port_sel,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  input wire serial_active,
  input wire [15:0] event_set,
  input wire [4:0] voltage_id_inputs,
  output reg mgmt_interrupt_out_n,
  output reg host_interrupt_out_n,
  output reg host_is_nmi,
  output reg reset_out_o,
  output reg reset_out_oe,
  output reg power_hold_o,
  output reg power_hold_oe,
  output reg monitor_run
);
  //////////////////////////////////////////////////////////////////
  // Register file
  reg [7:0] cfg_r;
  reg [7:0] st1_r;
  reg [7:0] st2_r;
  reg [7:0] mm1_r;
  reg [7:0] mm2_r;
  reg [7:0] hm1_r;
  reg [7:0] hm2_r;
  reg [3:0] fdiv_r;
  reg [6:0] sba_r;
  reg [6:0] ptr_r;
  reg [6:0] bufp_r;
  reg [6:0] rdp_r;
  reg busy_r;
  reg busy_idx_r;
  reg ser_q_r;
  reg rd_q_r;
  reg wr_q_r;
  reg [31:0] pcnt_r;
  // Code buffer and value RAM share one array
  reg [7:0] mem [0:127];
  //////////////////////////////////////////////////////////////////
  // Decoded strobes
  wire rd_stb;
  wire wr_stb;
  wire idx_wr;
  wire dat_acc;
  wire dat_wr;
  wire dat_rd;
  wire buf_wr;
  wire buf_ovf;
  wire soft_init;
  wire ser_rise;
  wire ser_fall;
  wire pulse_end;
  wire rst_keep;
  wire mgmt_req;
  wire host_req;
  wire [6:0] eff;
  wire [7:0] st2_ev;
  reg [7:0] rdv;
  //////////////////////////////////////////////////////////////////
  function is_value;
    input [6:0] a;
    begin
      is_value = (a >= `HWMRI_VAL_LO) && (a <= `HWMRI_VAL_HI);
    end
  endfunction
  //////////////////////////////////////////////////////////////////
  // R17 R18 second status layout
  function [7:0] st2_map;
    input [15:0] ev;
    input ovf;
    begin
      st2_map = {1'b0, ev[14], ovf, ev[12], ev[11:8]};
    end
  endfunction
  //////////////////////////////////////////////////////////////////
  function [6:0] next_ptr;
    input [6:0] p;
    begin
      if (p >= `HWMRI_VALI_LO)
        next_ptr = p + 7'h01;
      else if (p == `HWMRI_A_ST1 || p == `HWMRI_A_MM1 || p == `HWMRI_A_HM1)
        next_ptr = p + 7'h01;
      else
        next_ptr = p;
    end
  endfunction
  //////////////////////////////////////////////////////////////////
  function any_unmasked;
    input [15:0] st;
    input [15:0] mask;
    begin
      any_unmasked = |(st & ~mask);
    end
  endfunction
  //////////////////////////////////////////////////////////////////
  // Strobe edges; each access is taken once
  assign rd_stb = !io_rd_n && rd_q_r;
  assign wr_stb = !io_wr_n && wr_q_r;
  assign idx_wr = wr_stb && port_sel == `HWMRI_PORT_IDX;
  assign dat_acc = (rd_stb || wr_stb) && port_sel == `HWMRI_PORT_DAT;
  assign dat_wr = wr_stb && port_sel == `HWMRI_PORT_DAT;
  assign dat_rd = rd_stb && port_sel == `HWMRI_PORT_DAT;
  assign buf_wr = wr_stb && (port_sel == `HWMRI_PORT_PC0 || port_sel == `HWMRI_PORT_PC4);
  assign buf_ovf = buf_wr && bufp_r == `HWMRI_BUF_LAST;
  assign soft_init = cfg_r[`HWMRI_CFG_INIT];
  assign ser_rise = serial_active && !ser_q_r;
  assign ser_fall = !serial_active && ser_q_r;
  assign pulse_end = cfg_r[`HWMRI_CFG_RST] && (pcnt_r >= PULSE_CYC - 1);
  // Pulse bit is never cut short by a config write; only its timer, reset or soft init clears it
  assign rst_keep = cfg_r[`HWMRI_CFG_RST] && !pulse_end;
  assign eff = (ptr_r >= `HWMRI_VALI_LO) ? ptr_r - 7'h40 : ptr_r;
  assign st2_ev = st2_map(event_set, buf_ovf);
  assign mgmt_req = any_unmasked({st2_r, st1_r}, {mm2_r, mm1_r});
  assign host_req = any_unmasked({st2_r, st1_r}, {hm2_r, hm1_r});
  //////////////////////////////////////////////////////////////////
  always @*
  begin
    case (ptr_r)
      `HWMRI_A_CFG: rdv = cfg_r;
      `HWMRI_A_ST1: rdv = st1_r;
      `HWMRI_A_ST2: rdv = st2_r;
      `HWMRI_A_MM1: rdv = mm1_r;
      `HWMRI_A_MM2: rdv = mm2_r;
      `HWMRI_A_HM1: rdv = hm1_r;
      `HWMRI_A_HM2: rdv = hm2_r;
      `HWMRI_A_VFD: rdv = {fdiv_r, voltage_id_inputs[3:0]};
      `HWMRI_A_SBA: rdv = {1'b0, sba_r};
      `HWMRI_A_CRI: rdv = {DEV_ID, 6'h00, voltage_id_inputs[4]};
      default:
      begin
        if (ptr_r <= `HWMRI_BUF_LAST)
          rdv = mem[rdp_r];
        else if (is_value(eff))
          rdv = mem[eff];
        else
          rdv = 8'h00;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////
  // Previous levels for edge detection, idle values after reset
  always @(posedge clk)
  begin
    if (rst)
    begin
      rd_q_r <= 1'b1;
      wr_q_r <= 1'b1;
      ser_q_r <= 1'b0;
    end
    else
    begin
      rd_q_r <= io_rd_n;
      wr_q_r <= io_wr_n;
      ser_q_r <= serial_active;
    end
  end
  //////////////////////////////////////////////////////////////////
  // R14 address survives init
  always @(posedge clk)
  begin
    if (rst)
      sba_r <= `HWMRI_RST_SBA;
    else if (dat_wr && ptr_r == `HWMRI_A_SBA)
      sba_r <= data_in[6:0];
  end
  //////////////////////////////////////////////////////////////////
  // RAM contents are not cleared by any reset
  always @(posedge clk)
  begin
    if (dat_wr && is_value(eff))
      mem[eff] <= data_in;
    // R18 code capture write
    if (buf_wr)
      mem[bufp_r] <= data_in;
  end
  //////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rst || soft_init)
      ptr_r <= 7'h00;
    // R1 pointer write
    else if (idx_wr)
      ptr_r <= data_in[6:0];
    // R5 R6 R7 pointer advance
    else if (dat_acc)
      ptr_r <= next_ptr(ptr_r);
  end
  //////////////////////////////////////////////////////////////////
  // Read pointer wraps inside the code buffer
  always @(posedge clk)
  begin
    if (rst || soft_init)
      rdp_r <= 7'h00;
    else if (dat_rd && ptr_r <= `HWMRI_BUF_LAST)
      rdp_r <= {2'b00, rdp_r[4:0] + 5'h01};
  end
  //////////////////////////////////////////////////////////////////
  // R18 overflow stops buffer pointer
  always @(posedge clk)
  begin
    if (rst || soft_init)
      bufp_r <= 7'h00;
    else if (buf_wr && bufp_r != `HWMRI_BUF_LAST)
      bufp_r <= bufp_r + 7'h01;
  end
  //////////////////////////////////////////////////////////////////
  // R2 busy set and clear
  always @(posedge clk)
  begin
    if (rst || soft_init)
    begin
      busy_r <= 1'b0;
      busy_idx_r <= 1'b0;
    end
    else if (idx_wr)
    begin
      busy_r <= 1'b1;
      busy_idx_r <= 1'b1;
    end
    else if (ser_rise)
    begin
      busy_r <= 1'b1;
      busy_idx_r <= 1'b0;
    end
    else if (dat_acc && busy_idx_r)
      busy_r <= 1'b0;
    else if (ser_fall && !busy_idx_r)
      busy_r <= 1'b0;
  end
  //////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    // R14 soft init, R15 reset value
    if (rst || soft_init)
      cfg_r <= `HWMRI_RST_CFG;
    else
    begin
      // R11 pulse bit refused without enable
      if (dat_wr && ptr_r == `HWMRI_A_CFG)
        cfg_r <= {data_in[7:5], rst_keep || (data_in[4] && mm2_r[`HWMRI_MM2_RSTEN]), data_in[3:0]};
      else if (pulse_end)
        cfg_r[`HWMRI_CFG_RST] <= 1'b0;
      if (dat_wr && ptr_r == `HWMRI_A_CRI)
        cfg_r[`HWMRI_CFG_INIT] <= data_in[5];
    end
  end
  //////////////////////////////////////////////////////////////////
  // R11 pulse timing and self clear
  always @(posedge clk)
  begin
    if (rst || soft_init || !cfg_r[`HWMRI_CFG_RST] || pulse_end)
      pcnt_r <= 32'h0000_0000;
    else
      pcnt_r <= pcnt_r + 32'h0000_0001;
  end
  //////////////////////////////////////////////////////////////////
  // R19 R21 mask registers
  always @(posedge clk)
  begin
    if (rst || soft_init)
    begin
      mm1_r <= 8'h00;
      mm2_r <= 8'h00;
      hm1_r <= 8'h00;
      hm2_r <= `HWMRI_RST_HM2;
      fdiv_r <= `HWMRI_RST_VFD;
    end
    else if (dat_wr)
    begin
      case (ptr_r)
        `HWMRI_A_MM1: mm1_r <= data_in;
        `HWMRI_A_MM2: mm2_r <= data_in;
        `HWMRI_A_HM1: hm1_r <= data_in;
        `HWMRI_A_HM2: hm2_r <= data_in;
        `HWMRI_A_VFD: fdiv_r <= data_in[7:4];
        default: ;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////
  // R20 read clears, R16 R17 sets win
  always @(posedge clk)
  begin
    if (rst || soft_init)
    begin
      st1_r <= 8'h00;
      st2_r <= 8'h00;
    end
    else
    begin
      if (dat_rd && ptr_r == `HWMRI_A_ST1)
        st1_r <= event_set[7:0];
      else
        st1_r <= st1_r | event_set[7:0];
      if (dat_rd && ptr_r == `HWMRI_A_ST2)
        st2_r <= st2_ev;
      else
        st2_r <= st2_r | st2_ev;
    end
  end
  //////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rst)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      mgmt_interrupt_out_n <= 1'b1;
      host_interrupt_out_n <= 1'b1;
      host_is_nmi <= 1'b0;
      reset_out_o <= 1'b0;
      reset_out_oe <= 1'b0;
      power_hold_o <= 1'b0;
      power_hold_oe <= 1'b0;
      monitor_run <= 1'b0;
    end
    else
    begin
      // R4 read value held while strobe low
      if (rd_stb)
        data_out <= (port_sel == `HWMRI_PORT_IDX) ? {busy_r, ptr_r} : rdv;
      data_oe <= !io_rd_n && (port_sel == `HWMRI_PORT_IDX || port_sel == `HWMRI_PORT_DAT);
      // R19 R22 management line
      mgmt_interrupt_out_n <= !(mgmt_req && cfg_r[`HWMRI_CFG_MEN] && !cfg_r[`HWMRI_CFG_HOLD]);
      // R9 R10 R21 host line
      host_interrupt_out_n <= !(host_req && cfg_r[`HWMRI_CFG_HEN] && !cfg_r[`HWMRI_CFG_HOLD]);
      // R12 line personality
      host_is_nmi <= cfg_r[`HWMRI_CFG_SEL];
      // R11 reset drive
      reset_out_oe <= cfg_r[`HWMRI_CFG_RST];
      // R13 power hold drive
      power_hold_oe <= cfg_r[`HWMRI_CFG_PWR];
      // R8 R10 monitoring run
      monitor_run <= cfg_r[`HWMRI_CFG_START] && !cfg_r[`HWMRI_CFG_HOLD];
    end
  end
endmodule // hwmri_top

// >>> bench/hwmri_props.sv
`timescale 1ns/10ps
module hwmri_props #(parameter PULSE_CYC = 20) (
  input wire clk,
  input wire rst,
  input wire io_rd_n,
  input wire io_wr_n,
  input wire [2:0] port_sel,
  input wire data_oe,
  input wire mgmt_interrupt_out_n,
  input wire host_interrupt_out_n,
  input wire host_is_nmi,
  input wire reset_out_o,
  input wire reset_out_oe,
  input wire power_hold_o,
  input wire power_hold_oe,
  input wire monitor_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  integer cnt_r;
  wire dwr = !io_wr_n && port_sel == 3'h6;
  // Pulse length seen at the pin
  always @(posedge clk)
    cnt_r <= (rst || !reset_out_oe) ? 0 : cnt_r + 1;
  reset_quiet_a: assert property ($fell(rst) |-> mgmt_interrupt_out_n && host_interrupt_out_n && !monitor_run)
    else $error("irq or run after reset");
  nmi_sel_a: assert property ($changed(host_is_nmi) |-> $past(dwr))
    else $error("line select moved alone");
  hold_cause_a: assert property ($changed(power_hold_oe) |-> $past(dwr))
    else $error("power hold moved alone");
  run_cause_a: assert property ($changed(monitor_run) |-> $past(dwr))
    else $error("run moved alone");
  hold_drive_a: assert property (power_hold_oe |-> !power_hold_o)
    else $error("power hold drives high");
  rst_drive_a: assert property (reset_out_oe |-> !reset_out_o)
    else $error("reset pin drives high");
  pulse_len_a: assert property ($fell(reset_out_oe) |-> cnt_r >= PULSE_CYC)
    else $error("reset pulse short");
  read_oe_a: assert property ($fell(io_rd_n) && (port_sel == 3'h5 || port_sel == 3'h6) |=> data_oe)
    else $error("no read drive");
  cover property ($fell(reset_out_oe));
  cover property ($fell(mgmt_interrupt_out_n));
  cover property ($fell(host_interrupt_out_n));
endmodule // hwmri_props
bind hwmri_top hwmri_props #(.PULSE_CYC(PULSE_CYC)) i_hwmri_props (.clk(clk), .rst(rst),
  .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .port_sel(port_sel), .data_oe(data_oe),
  .mgmt_interrupt_out_n(mgmt_interrupt_out_n), .host_interrupt_out_n(host_interrupt_out_n),
  .host_is_nmi(host_is_nmi), .reset_out_o(reset_out_o), .reset_out_oe(reset_out_oe),
  .power_hold_o(power_hold_o), .power_hold_oe(power_hold_oe), .monitor_run(monitor_run));

// >>> bench/hwmri_host.sv
`timescale 1ns/10ps
module hwmri_host (
  input wire clk,
  input wire [7:0] data_out,
  input wire serial_active,
  output reg io_rd_n = 1'b1,
  output reg io_wr_n = 1'b1,
  output reg [2:0] port_sel = 3'h7,
  output reg [7:0] data_in = 8'h00
);
  task acc(input [2:0] p, input [7:0] d, input w, output [7:0] q);
  begin
    @(posedge clk);
    while (serial_active)
      @(posedge clk);
    port_sel <= p;
    data_in <= d;
    if (w)
      io_wr_n <= 1'b0;
    else
      io_rd_n <= 1'b0;
    @(posedge clk);
    // Read value stands while the strobe is low
    @(negedge clk);
    q = data_out;
    @(posedge clk);
    io_rd_n <= 1'b1;
    io_wr_n <= 1'b1;
    // Released bus must not look held
    data_in <= ~d;
    @(posedge clk);
  end
  endtask
endmodule // hwmri_host

// >>> bench/hwmri_top_bench.sv
`timescale 1ns/10ps
module hwmri_top_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg serial_active = 1'b0;
  reg [15:0] event_set = 16'h0000;
  reg [7:0] q;
  integer mismatches = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i;
  wire io_rd_n, io_wr_n, data_oe, mgmt_interrupt_out_n, host_interrupt_out_n, host_is_nmi;
  wire reset_out_o, reset_out_oe, power_hold_o, power_hold_oe, monitor_run;
  wire [2:0] port_sel;
  wire [7:0] data_in, data_out;
  wire [7:0] irqs = {6'h00, mgmt_interrupt_out_n, host_interrupt_out_n};
  wire [7:0] pins = {5'h00, host_is_nmi, power_hold_oe, reset_out_oe};
  always #5 clk = ~clk;
  hwmri_top #(.PULSE_CYC(20)) i_hwmri_top (.clk(clk), .rst(rst), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
    .port_sel(port_sel), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .serial_active(serial_active), .event_set(event_set), .voltage_id_inputs(5'h00),
    .mgmt_interrupt_out_n(mgmt_interrupt_out_n), .host_interrupt_out_n(host_interrupt_out_n),
    .host_is_nmi(host_is_nmi), .reset_out_o(reset_out_o), .reset_out_oe(reset_out_oe),
    .power_hold_o(power_hold_o), .power_hold_oe(power_hold_oe), .monitor_run(monitor_run));
  hwmri_host i_hwmri_host (.clk(clk), .data_out(data_out), .serial_active(serial_active),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .port_sel(port_sel), .data_in(data_in));
  task summarize;
  begin
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    #1;
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task wr(input [2:0] p, input [7:0] d);
    i_hwmri_host.acc(p, d, 1'b1, q);
  endtask
  task rd(input [2:0] p, input [7:0] e);
  begin
    i_hwmri_host.acc(p, 8'h00, 1'b0, q);
    chk(q, e);
  end
  endtask
  task rwr(input [7:0] a, input [7:0] d);
  begin
    wr(3'h5, a);
    wr(3'h6, d);
  end
  endtask
  task rrd(input [7:0] a, input [7:0] e);
  begin
    wr(3'h5, a);
    rd(3'h6, e);
  end
  endtask
  task ev(input [15:0] v);
  begin
    event_set <= v;
    @(posedge clk);
    event_set <= 16'h0000;
    repeat (2) @(posedge clk);
  end
  endtask
  task t_reset;
  begin
    rd(3'h5, 8'h00);
    rrd(8'h40, 8'h08);
    rrd(8'h46, 8'h40);
  end
  endtask
  task t_ptr;
  begin
    wr(3'h5, 8'h43);
    rd(3'h5, 8'hc3);
    wr(3'h6, 8'h5a);
    rd(3'h5, 8'h44);
    rrd(8'h43, 8'h5a);
    rwr(8'h60, 8'h33);
    rd(3'h5, 8'h61);
    rrd(8'h20, 8'h33);
    rd(3'h5, 8'h20);
    rwr(8'h45, 8'h00);
    rd(3'h5, 8'h46);
    rrd(8'h41, 8'h00);
    rd(3'h5, 8'h42);
  end
  endtask
  task t_irq;
  begin
    rwr(8'h40, 8'h03);
    ev(16'h0001);
    chk(irqs, 8'h01);
    rrd(8'h41, 8'h01);
    chk(irqs, 8'h03);
    rwr(8'h43, 8'h01);
    ev(16'h0001);
    chk(irqs, 8'h03);
    rwr(8'h40, 8'h07);
    ev(16'h0100);
    chk(irqs, 8'h00);
    rwr(8'h40, 8'h06);
    chk(irqs, 8'h00);
    rwr(8'h40, 8'h0e);
    chk(irqs, 8'h03);
    rwr(8'h40, 8'h06);
    chk(irqs, 8'h00);
    rrd(8'h42, 8'h01);
    chk(irqs, 8'h02);
  end
  endtask
  task t_st2;
  begin
    for (i = 0; i < 32; i = i + 1)
      wr(3'h0, i[7:0]);
    ev(16'h5000);
    rrd(8'h42, 8'h70);
    rrd(8'h00, 8'h00);
    rd(3'h6, 8'h01);
    wr(3'h5, 8'h20);
    serial_active <= 1'b1;
    repeat (3) @(posedge clk);
    serial_active <= 1'b0;
    rd(3'h5, 8'h20);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(3'h5, 8'h00);
    rrd(8'h40, 8'h08);
  end
  endtask
  task t_cfg;
  begin
    rwr(8'h44, 8'h80);
    rwr(8'h40, 8'h70);
    chk(pins, 8'h07);
    i = 0;
    while (reset_out_oe && i < 100)
    begin
      @(posedge clk);
      i = i + 1;
    end
    rrd(8'h40, 8'h60);
    rwr(8'h44, 8'h00);
    rwr(8'h40, 8'h10);
    chk(pins, 8'h00);
    rwr(8'h40, 8'h80);
    rrd(8'h40, 8'h08);
    rrd(8'h43, 8'h00);
  end
  endtask
  // Ceiling well above the few hundred cycles used
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_ptr;
    t_irq;
    t_cfg;
    t_st2;
    summarize;
  end
endmodule // hwmri_top_bench
